// [verilog/sfa_alarm.sv]
// Fault alarm relay, status lamps and AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "sfa_defs.svh"
module sfa_alarm #(
  parameter int unsigned FLASH_HALF_CYC = `SFA_FLASH_HALF_CYC,
  parameter int unsigned STRETCH_CYC    = `SFA_STRETCH_CYC
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Field inputs and switches
  input  wire sfa_pkg::sfa_in_t field_in,
  // Lamps, relay and interrupt
  output var sfa_pkg::sfa_lamp_t lamps,
  output logic                  relay_closed,
  output logic                  irq
);
  import sfa_pkg::*;

  localparam logic [`SFA_FLASH_W-1:0]   FLASH_LAST   = `SFA_FLASH_W'(FLASH_HALF_CYC - 1);
  localparam logic [`SFA_STRETCH_W-1:0] STRETCH_LAST = `SFA_STRETCH_W'(STRETCH_CYC - 1);

  sfa_in_t                      sy;
  sfa_state_t                   state_q;
  logic [3:0]                   settle_q;
  logic [`SFA_PORTS-1:0]        en_q;
  logic                         leader_en_q;
  logic                         alarm_on;
  logic                         port_fault;
  logic                         power_fault;
  logic                         ring_fault;
  logic                         fault_now;
  logic [`SFA_FLASH_W-1:0]      flash_cnt_q;
  logic                         flash_tick;
  logic                         flash_q;
  logic [`SFA_STRETCH_W-1:0]    stretch_q [`SFA_PORTS];
  logic [`SFA_PORTS-1:0]        stretch_busy;
  logic                         accept;
  logic                         wr_q;
  logic [`SFA_ADDR_W-1:0]       waddr_q;
  logic                         rd_clr;
  logic [31:0]                  rd_val;
  logic [`SFA_EV_W-1:0]         event_q;
  logic [`SFA_EV_W-1:0]         mask_q;
  logic [`SFA_EV_W-1:0]         ev_set;
  logic [`SFA_PORTS-1:0]        link_prev_q;
  logic                         primary_power_indicator_prev_q;
  logic                         backup_power_indicator_prev_q;
  logic                         ring_prev_q;
  logic                         fault_prev_q;

  // Lamp on with link, blinking while traffic is seen
  function automatic logic sfa_blink(input logic up, input logic busy, input logic phase);
    sfa_blink = up & (~busy | phase);
  endfunction

  sfa_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw_in  (field_in),
    .synced  (sy)
  );

  // Power-up sequence: let the synchroniser settle, then take the switches once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q  <= SFA_ST_SETTLE;
      settle_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        SFA_ST_SETTLE:
        begin
          settle_q <= settle_q + 4'h1;
          if (settle_q == `SFA_SETTLE_CYC - 4'h1)
            state_q <= SFA_ST_SAMPLE;
        end
        SFA_ST_SAMPLE:
          state_q <= SFA_ST_RUN;
        SFA_ST_RUN:
          state_q <= SFA_ST_RUN;
        default:
          state_q <= SFA_ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q        <= '0;
      leader_en_q <= 1'b0;
    end
    else if (state_q == SFA_ST_SAMPLE)
    begin
      en_q        <= sy.port_alarm_sw;
      leader_en_q <= sy.ring_leader_sw;
    end
  end

  // Fault decision
  assign alarm_on    = (|en_q) | leader_en_q;
  assign port_fault  = |(en_q & ~sy.port_link);
  assign power_fault = ~(sy.primary_power_good & sy.backup_power_good);
  assign ring_fault  = leader_en_q & sy.ring_break;
  assign fault_now   = (state_q == SFA_ST_RUN) & alarm_on
                       & (port_fault | power_fault | ring_fault);

  // Relay opens to signal the external alarm device
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      relay_closed <= 1'b1;
    else
      relay_closed <= ~fault_now;
  end

  // Free-running flash divider
  assign flash_tick = (flash_cnt_q == FLASH_LAST);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end
    else if (flash_tick)
    begin
      flash_cnt_q <= '0;
      flash_q     <= ~flash_q;
    end
    else
      flash_cnt_q <= flash_cnt_q + 1'b1;
  end

  // Activity stretch so a short burst stays visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < `SFA_PORTS; i++)
        stretch_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < `SFA_PORTS; i++)
      begin
        if (sy.port_tx_act[i])
          stretch_q[i] <= STRETCH_LAST;
        else if (stretch_busy[i])
          stretch_q[i] <= stretch_q[i] - 1'b1;
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < `SFA_PORTS; i++)
      stretch_busy[i] = (stretch_q[i] != '0) | sy.port_tx_act[i];
  end

  // Lamps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lamps <= '0;
    else
    begin
      lamps.fault_indicator         <= fault_now;
      lamps.primary_power_indicator <= sy.primary_power_good;
      lamps.backup_power_indicator  <= sy.backup_power_good;
      if (sy.ring_break)
        lamps.ring_leader_indicator <= flash_q;
      else
        lamps.ring_leader_indicator <= sy.ring_leader_now;
      for (int i = 0; i < `SFA_COPPER; i++)
      begin
        lamps.low_speed_link_indicator[i] <=
          sfa_blink(sy.port_link[i] & ~sy.copper_speed_100[i], stretch_busy[i], flash_q);
        lamps.high_speed_link_indicator[i] <=
          sfa_blink(sy.port_link[i] & sy.copper_speed_100[i], stretch_busy[i], flash_q);
      end
      for (int i = `SFA_COPPER; i < `SFA_PORTS; i++)
        lamps.high_speed_link_indicator[i] <=
          sfa_blink(sy.port_link[i], stretch_busy[i], flash_q);
    end
  end

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign accept    = hsel & htrans[1] & hready & (hsize == `SFA_HSIZE_WORD);
  assign rd_clr    = accept & ~hwrite & (haddr[`SFA_ADDR_W-1:0] == `SFA_OFF_EVENT);

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (haddr[`SFA_ADDR_W-1:0])
      `SFA_OFF_STATUS:
        rd_val[`SFA_STATUS_W-1:0] = {alarm_on, sy.ring_leader_now, lamps.fault_indicator,
                                     sy.ring_break, sy.backup_power_good,
                                     sy.primary_power_good, sy.port_link};
      `SFA_OFF_EVENT:
        rd_val[`SFA_EV_W-1:0] = event_q;
      `SFA_OFF_MASK:
        rd_val[`SFA_EV_W-1:0] = mask_q;
      `SFA_OFF_CONFIG:
        rd_val[`SFA_CONFIG_W-1:0] = {leader_en_q, en_q};
      default:
        rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q    <= 1'b0;
      waddr_q <= '0;
      hrdata  <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= accept & hwrite;
      if (accept)
        waddr_q <= haddr[`SFA_ADDR_W-1:0];
      if (accept & ~hwrite)
        hrdata <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_q <= `SFA_MASK_RST;
    else if (wr_q && (waddr_q == `SFA_OFF_MASK))
      mask_q <= hwdata[`SFA_EV_W-1:0];
  end

  // Event detection on synchronised levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link_prev_q  <= '0;
      primary_power_indicator_prev_q  <= 1'b0;
      backup_power_indicator_prev_q  <= 1'b0;
      ring_prev_q  <= 1'b0;
      fault_prev_q <= 1'b0;
    end
    else
    begin
      link_prev_q  <= sy.port_link;
      primary_power_indicator_prev_q  <= sy.primary_power_good;
      backup_power_indicator_prev_q  <= sy.backup_power_good;
      ring_prev_q  <= sy.ring_break;
      fault_prev_q <= fault_now;
    end
  end

  always_comb
  begin
    ev_set                  = '0;
    ev_set[`SFA_PORTS-1:0]  = link_prev_q & ~sy.port_link;
    ev_set[`SFA_BIT_PRIMARY_POWER_INDICATOR]   = primary_power_indicator_prev_q & ~sy.primary_power_good;
    ev_set[`SFA_BIT_BACKUP_POWER_INDICATOR]   = backup_power_indicator_prev_q & ~sy.backup_power_good;
    ev_set[`SFA_BIT_RING]   = sy.ring_break & ~ring_prev_q;
    ev_set[`SFA_BIT_FAULT]  = fault_now & ~fault_prev_q;
  end

  // Read clears, a new event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      event_q <= '0;
    else if (rd_clr)
      event_q <= ev_set;
    else
      event_q <= event_q | ev_set;
  end

  assign irq = |(event_q & mask_q);

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_running;
    state_q == SFA_ST_RUN;
  endsequence

  sequence s_act_seen;
    sy.port_tx_act[0] ##1 !sy.port_tx_act[0];
  endsequence

  a_port_fault_lamp: assert property (
    s_running and (alarm_on && port_fault) |=> lamps.fault_indicator && !relay_closed)
    else $error("enabled port without link did not raise the fault");
  a_power_fault_lamp: assert property (
    s_running and (alarm_on && !sy.backup_power_good) |=> lamps.fault_indicator)
    else $error("backup power loss did not light the fault lamp");
  a_alarm_gate_off: assert property (
    !alarm_on |=> relay_closed && !lamps.fault_indicator)
    else $error("fault raised with every alarm switch off");
  a_relay_tracks_fault: assert property (
    lamps.fault_indicator == !relay_closed)
    else $error("relay and fault lamp disagree");
  a_power_lamps_follow: assert property (
    ##1 lamps.primary_power_indicator == $past(sy.primary_power_good)
        && lamps.backup_power_indicator == $past(sy.backup_power_good))
    else $error("power lamps do not follow power inputs");
  a_fiber_link_steady: assert property (
    sy.port_link[4] && !stretch_busy[4] |=> lamps.high_speed_link_indicator[4])
    else $error("fiber lamp not steady on idle link");
  a_leader_lamp_steady: assert property (
    sy.ring_leader_now && !sy.ring_break |=> lamps.ring_leader_indicator)
    else $error("leader lamp off while leading an intact ring");
  a_leader_lamp_flash: assert property (
    sy.ring_break |=> lamps.ring_leader_indicator == $past(flash_q))
    else $error("leader lamp not flashing on ring break");
  a_low_speed_lamp: assert property (
    sy.port_link[0] && !sy.copper_speed_100[0] && !stretch_busy[0]
    |=> lamps.low_speed_link_indicator[0] && !lamps.high_speed_link_indicator[0])
    else $error("low speed lamp wrong on idle 10 Mb/s link");
  a_high_speed_lamp: assert property (
    sy.port_link[0] && sy.copper_speed_100[0] && stretch_busy[0] && !flash_q
    |=> !lamps.high_speed_link_indicator[0] && !lamps.low_speed_link_indicator[0])
    else $error("high speed lamp not blinking dark on busy link");
  a_ring_needs_leader: assert property (
    s_running and (!leader_en_q && !port_fault && !power_fault) |=> relay_closed)
    else $error("ring break opened relay without leader switch");
  a_config_frozen: assert property (
    s_running |=> $stable(en_q) && $stable(leader_en_q))
    else $error("switch settings changed after power-up");
  a_stretch_holds: assert property (
    s_act_seen |-> stretch_busy[0] [*8])
    else $error("activity stretch too short");
  a_flash_toggles: assert property (
    flash_tick |=> flash_q != $past(flash_q) && !flash_tick)
    else $error("flash divider did not toggle");
  a_sync_two_stage: assert property (
    ##2 sy.ring_break == $past(field_in.ring_break, 2))
    else $error("inputs not passed through two stages");
  a_read_clear_set_wins: assert property (
    rd_clr && ev_set[`SFA_BIT_FAULT] |=> event_q[`SFA_BIT_FAULT])
    else $error("event lost on read clear");
endmodule // sfa_alarm
`default_nettype wire

// [verilog/sfa_defs.svh]
// Constants for the switch fault alarm and status lamp block
`ifndef SFA_DEFS_SVH
`define SFA_DEFS_SVH

`define SFA_PORTS          5
`define SFA_COPPER         3
`define SFA_ADDR_W         12
`define SFA_OFF_STATUS     12'h000
`define SFA_OFF_EVENT      12'h004
`define SFA_OFF_MASK       12'h008
`define SFA_OFF_CONFIG     12'h00c
`define SFA_HSIZE_WORD     3'b010
`define SFA_EV_W           9
`define SFA_BIT_PRIMARY_POWER_INDICATOR       5
`define SFA_BIT_BACKUP_POWER_INDICATOR       6
`define SFA_BIT_RING       7
`define SFA_BIT_FAULT      8
`define SFA_STATUS_W       11
`define SFA_CONFIG_W       6
`define SFA_MASK_RST       9'h000
`define SFA_SETTLE_CYC     4'h4
`define SFA_CLK_HZ         50000000
`define SFA_FLASH_HALF_MS  250
`define SFA_STRETCH_MS     50
`define SFA_FLASH_HALF_CYC (`SFA_CLK_HZ / 1000 * `SFA_FLASH_HALF_MS)
`define SFA_STRETCH_CYC    (`SFA_CLK_HZ / 1000 * `SFA_STRETCH_MS)
`define SFA_FLASH_W        24
`define SFA_STRETCH_W      22

`endif

// [verilog/sfa_pkg.sv]
// Types shared by the switch fault alarm block
`default_nettype none
package sfa_pkg;
  typedef enum logic [1:0] {
    SFA_ST_SETTLE = 2'b00,
    SFA_ST_SAMPLE = 2'b01,
    SFA_ST_RUN    = 2'b11
  } sfa_state_t;

  typedef struct packed {
    logic [4:0] port_link;
    logic [2:0] copper_speed_100;
    logic [4:0] port_tx_act;
    logic       primary_power_good;
    logic       backup_power_good;
    logic       ring_leader_now;
    logic       ring_break;
    logic [4:0] port_alarm_sw;
    logic       ring_leader_sw;
  } sfa_in_t;

  typedef struct packed {
    logic       fault_indicator;
    logic       primary_power_indicator;
    logic       backup_power_indicator;
    logic       ring_leader_indicator;
    logic [2:0] low_speed_link_indicator;
    logic [4:0] high_speed_link_indicator;
  } sfa_lamp_t;
endpackage
`default_nettype wire

// [verilog/sfa_sync.sv]
// Two-stage synchroniser for the field inputs
`timescale 1ns/100ps
`default_nettype none
module sfa_sync (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Raw and synchronised inputs
  input  wire sfa_pkg::sfa_in_t raw_in,
  output var sfa_pkg::sfa_in_t  synced
);
  import sfa_pkg::*;

  sfa_in_t meta_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= '0;
      synced <= '0;
    end
    else
    begin
      meta_q <= raw_in;
      synced <= meta_q;
    end
  end
endmodule // sfa_sync
`default_nettype wire

// [verification/sfa_far_side.sv]
// Far-side model: warning light on the relay contacts and lamp watcher
`timescale 1ns/100ps
`default_nettype none
module sfa_far_side (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Relay contacts and lamps
  input  wire logic               relay_closed,
  input  wire sfa_pkg::sfa_lamp_t lamps,
  // Observation
  input  wire logic               clr,
  output logic                    alarm_light,
  output logic [11:0]             toggled
);
  import sfa_pkg::*;
  logic [11:0] prev_q;
  // Light glows while the contacts are open
  assign alarm_light = !relay_closed;
  // Sticky record of lamp changes, shows flashing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_q  <= 12'h000;
      toggled <= 12'h000;
    end
    else
    begin
      prev_q  <= lamps;
      toggled <= clr ? 12'h000 : (toggled | (lamps ^ prev_q));
    end
  end
endmodule // sfa_far_side
`default_nettype wire

// [verification/switch_fault_alarm_status_indicators_test.sv]
// Self-checking bench for the fault alarm and status lamp block
`timescale 1ns/100ps
`default_nettype none
module switch_fault_alarm_status_indicators_test;
  import sfa_pkg::*;
  localparam int unsigned HALF = 16;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  sfa_in_t     fi = '0;
  sfa_in_t     f;
  sfa_lamp_t   lamps;
  logic        relay_closed;
  logic        irq;
  logic        clr = 1'b0;
  logic        alarm_light;
  logic [11:0] toggled;
  logic [31:0] rd;
  logic [31:0] r;
  logic [4:0]  sw = 5'h00;
  logic        ls = 1'b0;
  logic        e;
  integer      seed = 32'h24183a79;
  int          n_mismatch = 0;
  int          checks = 0;

  sfa_alarm #(.FLASH_HALF_CYC(HALF), .STRETCH_CYC(HALF)) i_sfa_alarm (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .field_in(fi), .lamps(lamps),
    .relay_closed(relay_closed), .irq(irq));

  sfa_far_side i_sfa_far_side (
    .hclk(hclk), .hresetn(hresetn), .relay_closed(relay_closed), .lamps(lamps),
    .clr(clr), .alarm_light(alarm_light), .toggled(toggled));

  always #10 hclk = ~hclk;

  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        n_mismatch++;
        end_of_test();
      end
      @(posedge hclk);
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_ready();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask

  function automatic sfa_in_t good;
    sfa_in_t g;
    g = '0;
    g.port_link = 5'h1f;
    g.primary_power_good = 1'b1;
    g.backup_power_good = 1'b1;
    g.port_alarm_sw = sw;
    g.ring_leader_sw = ls;
    return g;
  endfunction

  function automatic logic efault(input sfa_in_t v);
    return ((|sw) | ls) & ((|(sw & ~v.port_link)) | !v.primary_power_good
           | !v.backup_power_good | (ls & v.ring_break));
  endfunction

  task automatic reset_dut;
    hresetn <= 1'b0;
    fi      <= good();
    repeat (10) @(posedge hclk);
    check({lamps, relay_closed, irq}, {12'h000, 2'b10});
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask

  initial
  begin
    for (int p = 0; p < 5; p++)
    begin
      r  = $random(seed);
      sw = (p == 0) ? r[4:0] : ((p >= 3) ? 5'h1f : 5'h00);
      ls = (p == 0) ? r[5] : (p == 2 || p == 4);
      reset_dut();
      ahb(1'b0, 12'h00c, 32'h0);
      check(rd, {26'h0, ls, sw});
      ahb(1'b1, 12'h00c, {26'h0, ~ls, ~sw});
      ahb(1'b0, 12'h00c, 32'h0);
      check(rd, {26'h0, ls, sw});
      ahb(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 12; i++)
      begin
        r = $random(seed);
        f = sfa_in_t'(r[22:0]);
        // Corner: ring break with every link and supply healthy
        if (i == 0)
          f = good();
        f.ring_break = f.ring_break | (i == 0);
        f.port_tx_act = 5'h00;
        fi <= f;
        repeat (24) @(posedge hclk);
        e = efault(f);
        check(lamps.fault_indicator, e);
        check(relay_closed, {!e});
        check(alarm_light, e);
        check({lamps.primary_power_indicator, lamps.backup_power_indicator},
              {f.primary_power_good, f.backup_power_good});
        check(lamps.high_speed_link_indicator,
              {f.port_link[4:3], f.port_link[2:0] & f.copper_speed_100});
        check(lamps.low_speed_link_indicator, {f.port_link[2:0] & ~f.copper_speed_100});
        if (!f.ring_break)
          check(lamps.ring_leader_indicator, f.ring_leader_now);
        ahb(1'b0, 12'h000, 32'h0);
        check(rd, {21'h0, (|sw) | ls, f.ring_leader_now, e, f.ring_break,
              f.backup_power_good, f.primary_power_good, f.port_link});
      end
    end
    // Interrupt: raise, clear by read, mask
    fi <= good();
    repeat (6) @(posedge hclk);
    ahb(1'b0, 12'h004, 32'h0);
    ahb(1'b1, 12'h008, 32'h1);
    check(irq, 1'b0);
    fi.port_link[0] <= 1'b0;
    repeat (2) @(posedge hclk);
    // Read lands on the edge that records the loss
    ahb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    check(irq, 1'b1);
    ahb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h101);
    check(irq, 1'b0);
    fi.port_link[0] <= 1'b1;
    repeat (5) @(posedge hclk);
    ahb(1'b1, 12'h008, 32'h20);
    fi.port_link[0] <= 1'b0;
    repeat (5) @(posedge hclk);
    check(irq, 1'b0);
    fi.primary_power_good <= 1'b0;
    repeat (5) @(posedge hclk);
    check(irq, 1'b1);
    ahb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h20);
    ahb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h121);
    // Traffic and ring break make lamps flash
    f = good();
    f.copper_speed_100 = 3'b101;
    f.port_tx_act = 5'h1f;
    f.ring_break = 1'b1;
    f.ring_leader_now = 1'b1;
    fi <= f;
    repeat (6) @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (80) @(posedge hclk);
    check(toggled, 12'h15d);
    check(lamps.fault_indicator, 1'b1);
    f.port_tx_act = 5'h00;
    f.ring_break = 1'b0;
    fi <= f;
    repeat (40) @(posedge hclk);
    check(lamps, 12'h75d);
    end_of_test();
  end
endmodule // switch_fault_alarm_status_indicators_test
`default_nettype wire
